// File: rtl/gdi_pkg.sv
package gdi_pkg;

   // Clocks and the serial rate ceiling
   localparam int MCLK_HZ = 40_000_000;
   localparam int SCLK_MAX_HZ = 4_000_000;
   // Shortest serial clock phase seen in mclk cycles (rounded down)
   localparam int SCLK_HALF_CYC = MCLK_HZ / (2 * SCLK_MAX_HZ);

   // Serial frame
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_BITS_W = 5'h10;
   localparam logic [4:0] FRAME_CNT_MAX = 5'h11;

   // Fault vector: bit 0 is the shoot-through flag, 4:1 external faults
   localparam int NUM_FAULTS = 5;
   localparam int FAULT_STP_BIT = 0;
   localparam int EXT_FAULTS = 4;

   // Configuration word layout and reset value
   localparam int CFG_ALARM_MASK_LSB = 0;
   localparam int CFG_WARN_MASK_LSB = 5;
   localparam int CFG_ALT_BIT = 10;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // Converter width for the duty output
   localparam int ADC_BITS = 10;

   // Synchronised pin vector positions
   localparam int PIN_NUM = 8;
   localparam int PIN_PWM_POS = 0;
   localparam int PIN_PWM_NEG = 1;
   localparam int PIN_OVR_EN = 2;
   localparam int PIN_OVR_LVL = 3;
   localparam int PIN_DRV_EN = 4;
   localparam int PIN_CS_N = 5;
   localparam int PIN_SCLK = 6;
   localparam int PIN_SDI = 7;
   // Idle pin levels: only the chip select rests high, so no false edge
   localparam logic [7:0] PIN_RST_VAL = 8'h20;

   typedef enum logic [1:0] {
      GDI_DRV_OFF = 2'b00,
      GDI_DRV_PWM = 2'b01,
      GDI_DRV_OVR = 2'b10
   } gdi_mode_e;

endpackage

// File: rtl/gdi_sync.sv
`timescale 1ns/1ps
module gdi_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] nxt_meta;
   logic [W-1:0] nxt_q;

   always_comb begin
      nxt_meta = d;
      nxt_q = meta_ff;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         // Reset to the pins' idle levels, not zero, to avoid fake edges
         meta_ff <= RST_VAL;
         q_ff <= RST_VAL;
      end else begin
         meta_ff <= nxt_meta;
         q_ff <= nxt_q;
      end
   end

   assign q = q_ff;
endmodule

// File: rtl/gdi_top.sv
`timescale 1ns/1ps
// What this block does
// - Override enable forces output to override level
// - Override high sources gate, low sinks it
// - Normal mode: gate follows positive PWM input
// - Both PWM inputs high flags shoot-through
// - Unmasked fault pulls alarm output low
// - Alarm high when faults absent or masked
// - Warning pin low on unmasked routed fault
// - Alternate warning pin carries converter duty PWM
// - Serial port works up to 4 MHz
// - Serial clock and data ignored while deselected
// - Sample data on falling, update on rising
module gdi_top
   import gdi_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Drive command pins
   input wire logic pwm_in_pos,
   input wire logic pwm_in_neg_interlock,
   input wire logic short_circuit_override_enable,
   input wire logic short_circuit_level,
   input wire logic driver_enable,
   // Serial configuration port
   input wire logic chip_select_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   // Same-domain fault sources and converter code
   input wire logic [EXT_FAULTS-1:0] fault_in,
   input wire logic [ADC_BITS-1:0] adc_code,
   // Gate drive and indication
   output logic gate_source_out,
   output logic gate_sink_out,
   output logic shoot_through_fault,
   output logic fault_alarm_n,
   output logic warning_out_n
);

   function automatic logic fault_hit(input logic [NUM_FAULTS-1:0] f,
                                      input logic [NUM_FAULTS-1:0] m);
      return |(f & ~m);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [PIN_NUM-1:0] pins;
   logic [PIN_NUM-1:0] pin_s;

   assign pins = {sdi, sclk, chip_select_n, driver_enable,
                  short_circuit_level, short_circuit_override_enable,
                  pwm_in_neg_interlock, pwm_in_pos};

   gdi_sync #(.W(PIN_NUM), .RST_VAL(PIN_RST_VAL)) u_sync (
      .mclk(mclk),
      .rst_b(rst_b),
      .d(pins),
      .q(pin_s)
   );

   logic pwm_pos_s, pwm_neg_s, ovr_en_s, ovr_lvl_s, drv_en_s;
   logic cs_n_s, sclk_s, sdi_s;
   assign pwm_pos_s = pin_s[PIN_PWM_POS];
   assign pwm_neg_s = pin_s[PIN_PWM_NEG];
   assign ovr_en_s = pin_s[PIN_OVR_EN];
   assign ovr_lvl_s = pin_s[PIN_OVR_LVL];
   assign drv_en_s = pin_s[PIN_DRV_EN];
   assign cs_n_s = pin_s[PIN_CS_N];
   assign sclk_s = pin_s[PIN_SCLK];
   assign sdi_s = pin_s[PIN_SDI];

   ////////////////////////////////////////////////////////////////////////
   // Serial configuration port
   // Two-stage sync plus edge detect needs a few mclk per phase; at the
   // 4 MHz ceiling each phase spans SCLK_HALF_CYC cycles, enough margin.
   logic sclk_d_ff, cs_d_ff, sdo_ff;
   logic [FRAME_BITS-1:0] rx_ff, tx_ff, cfg_ff;
   logic [4:0] bcnt_ff;
   logic nxt_sclk_d, nxt_cs_d, nxt_sdo;
   logic [FRAME_BITS-1:0] nxt_rx, nxt_tx, nxt_cfg;
   logic [4:0] nxt_bcnt;
   logic sclk_fall, sclk_rise, cs_fall, cs_rise;

   assign sclk_fall = sclk_d_ff & ~sclk_s;
   assign sclk_rise = ~sclk_d_ff & sclk_s;
   assign cs_fall = cs_d_ff & ~cs_n_s;
   assign cs_rise = ~cs_d_ff & cs_n_s;

   always_comb begin
      nxt_sclk_d = sclk_s;
      nxt_cs_d = cs_n_s;
      nxt_rx = rx_ff;
      nxt_tx = tx_ff;
      nxt_bcnt = bcnt_ff;
      nxt_sdo = sdo_ff;
      nxt_cfg = cfg_ff;
      if (cs_fall) begin
         nxt_rx = '0;
         nxt_tx = cfg_ff;
         nxt_bcnt = '0;
         nxt_sdo = 1'b0;
      end else if (!cs_n_s) begin
         if (sclk_fall) begin
            nxt_rx = {rx_ff[FRAME_BITS-2:0], sdi_s};
            if (bcnt_ff != FRAME_CNT_MAX) begin
               nxt_bcnt = 5'(bcnt_ff + 5'h01);
            end
         end
         if (sclk_rise) begin
            nxt_sdo = tx_ff[FRAME_BITS-1];
            nxt_tx = {tx_ff[FRAME_BITS-2:0], 1'b0};
         end
      end else begin
         // Deselected: clock and data have no effect
         nxt_sdo = 1'b0;
      end
      // Only a whole frame updates the configuration
      if (cs_rise && bcnt_ff == FRAME_BITS_W) begin
         nxt_cfg = rx_ff;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
         rx_ff <= '0;
         tx_ff <= '0;
         bcnt_ff <= '0;
         sdo_ff <= 1'b0;
         cfg_ff <= CFG_RESET;
      end else begin
         sclk_d_ff <= nxt_sclk_d;
         cs_d_ff <= nxt_cs_d;
         rx_ff <= nxt_rx;
         tx_ff <= nxt_tx;
         bcnt_ff <= nxt_bcnt;
         sdo_ff <= nxt_sdo;
         cfg_ff <= nxt_cfg;
      end
   end

   assign sdo = sdo_ff;

   ////////////////////////////////////////////////////////////////////////
   // Gate drive and indication
   logic [NUM_FAULTS-1:0] faults, alarm_mask, warn_mask;
   logic alt_mode, duty, stp_now;
   gdi_mode_e mode;
   logic src_ff, snk_ff, stp_ff, alarm_n_ff, warn_n_ff;
   logic [ADC_BITS-1:0] pcnt_ff;
   logic nxt_src, nxt_snk, nxt_stp, nxt_alarm_n, nxt_warn_n;
   logic [ADC_BITS-1:0] nxt_pcnt;

   assign stp_now = pwm_pos_s & pwm_neg_s;
   assign faults = {fault_in, stp_now};
   assign alarm_mask = cfg_ff[CFG_ALARM_MASK_LSB +: NUM_FAULTS];
   assign warn_mask = cfg_ff[CFG_WARN_MASK_LSB +: NUM_FAULTS];
   assign alt_mode = cfg_ff[CFG_ALT_BIT];
   // Free-running ramp; duty resolution is one converter LSB
   assign duty = pcnt_ff < adc_code;

   always_comb begin
      if (ovr_en_s) begin
         mode = GDI_DRV_OVR;
      end else if (drv_en_s) begin
         mode = GDI_DRV_PWM;
      end else begin
         mode = GDI_DRV_OFF;
      end
      unique case (mode)
         GDI_DRV_OVR: nxt_src = ovr_lvl_s;
         GDI_DRV_PWM: nxt_src = pwm_pos_s;
         default: nxt_src = 1'b0;
      endcase
      // Never both: sink whenever not sourcing, so gate defaults low
      nxt_snk = ~nxt_src;
      nxt_stp = stp_now;
      nxt_alarm_n = ~fault_hit(faults, alarm_mask);
      nxt_warn_n = alt_mode ? duty : ~fault_hit(faults, warn_mask);
      nxt_pcnt = ADC_BITS'(pcnt_ff + 1'b1);
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         src_ff <= 1'b0;
         snk_ff <= 1'b1;
         stp_ff <= 1'b0;
         alarm_n_ff <= 1'b1;
         warn_n_ff <= 1'b1;
         pcnt_ff <= '0;
      end else begin
         src_ff <= nxt_src;
         snk_ff <= nxt_snk;
         stp_ff <= nxt_stp;
         alarm_n_ff <= nxt_alarm_n;
         warn_n_ff <= nxt_warn_n;
         pcnt_ff <= nxt_pcnt;
      end
   end

   assign gate_source_out = src_ff;
   assign gate_sink_out = snk_ff;
   assign shoot_through_fault = stp_ff;
   assign fault_alarm_n = alarm_n_ff;
   assign warning_out_n = warn_n_ff;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_ovr_level: assert property (
      ovr_en_s |=> gate_source_out == $past(ovr_lvl_s))
      else $error("override level not followed");
   a_ovr_sink: assert property (
      ovr_en_s && !ovr_lvl_s |=> gate_sink_out && !gate_source_out)
      else $error("override low did not sink gate");
   a_pwm_follow: assert property (
      !ovr_en_s && drv_en_s |=> gate_source_out == $past(pwm_pos_s)
      && gate_sink_out == !$past(pwm_pos_s))
      else $error("gate does not follow pwm input");
   a_stp_flag: assert property (
      pwm_pos_s && pwm_neg_s |=> shoot_through_fault
      && (!fault_alarm_n || $past(alarm_mask[FAULT_STP_BIT])))
      else $error("overlap not flagged");
   a_alarm_low: assert property (
      fault_hit(faults, alarm_mask) |=> !fault_alarm_n)
      else $error("unmasked fault did not pull alarm low");
   a_alarm_high: assert property (
      !fault_hit(faults, alarm_mask) |=> fault_alarm_n)
      else $error("alarm low without unmasked fault");
   a_warn_ind: assert property (
      !alt_mode |=> warning_out_n == !$past(fault_hit(faults, warn_mask)))
      else $error("warning indicator wrong");
   a_warn_duty: assert property (
      alt_mode |=> warning_out_n == $past(duty))
      else $error("warning pin not carrying duty");
   a_cs_ignore: assert property (
      cs_n_s && cs_d_ff |=> $stable(rx_ff) && !sdo)
      else $error("serial activity while deselected");
   a_rx_fall: assert property (
      !cs_n_s && !cs_fall && sclk_fall |=> rx_ff[0] == $past(sdi_s))
      else $error("data not sampled on falling edge");
   a_sdo_rise: assert property (
      !cs_n_s && !cs_fall && sclk_rise |=> sdo == $past(tx_ff[15]))
      else $error("output not updated on rising edge");
   a_cfg_frame: assert property (
      cs_rise && bcnt_ff != FRAME_BITS_W |=> $stable(cfg_ff))
      else $error("partial frame changed configuration");

   c_override: cover property (ovr_en_s ##1 gate_source_out);
   c_overlap: cover property (stp_now ##1 shoot_through_fault);
   c_cfg_load: cover property (cs_rise && bcnt_ff == FRAME_BITS_W);
   c_alt_mode: cover property (alt_mode && !warning_out_n);
endmodule

// File: verification/gdi_host_model.sv
`timescale 1ns/1ps
module gdi_host_model
   import gdi_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Serial port toward the device
   output logic chip_select_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   initial begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end

   // Five mclk per phase keeps the serial clock at its 4 MHz ceiling
   task automatic half_period();
      repeat (5) @(negedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Data changes with the rise, so it is steady across the sampling fall
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] rd);
      rd = 16'h0000;
      chip_select_n = 1'b0;
      half_period();
      for (int i = 15; i > 15 - n; i--) begin
         sclk = 1'b1;
         sdi = w[i];
         half_period();
         rd = {rd[14:0], sdo};
         sclk = 1'b0;
         half_period();
      end
      chip_select_n = 1'b1;
      // Released line shows the inverse, not a stale bit
      sdi = ~sdi;
      half_period();
   endtask

   // Clock and data wiggle while deselected
   task automatic idle_toggle();
      for (int i = 0; i < 16; i++) begin
         sclk = ~sclk;
         sdi = ~sdi;
         half_period();
      end
   endtask
endmodule

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top
   import gdi_pkg::*;
;
   typedef struct packed {
      logic [4:0] pins;
      logic [3:0] flt;
      logic [3:0] exp;
   } gdi_row_s;

   logic mclk, rst_b, pwm_in_pos, pwm_in_neg_interlock, driver_enable;
   logic short_circuit_override_enable, short_circuit_level;
   logic chip_select_n, sclk, sdi, sdo;
   logic [EXT_FAULTS-1:0] fault_in;
   logic [ADC_BITS-1:0] adc_code;
   logic gate_source_out, gate_sink_out, shoot_through_fault;
   logic fault_alarm_n, warning_out_n;
   logic [15:0] rd, cnt;
   int failures = 0;
   int samples_checked = 0;
   // Pins {pos, neg, ovr_en, ovr_lvl, drv_en}; exp {src, stp, alarm, warn}
   gdi_row_s rows [9] = '{
      '{5'b10001, 4'h0, 4'b1011}, '{5'b00001, 4'h0, 4'b0011},
      '{5'b11001, 4'h0, 4'b1100}, '{5'b00110, 4'h0, 4'b1011},
      '{5'b10101, 4'h0, 4'b0011}, '{5'b10000, 4'h0, 4'b0011},
      '{5'b00001, 4'h1, 4'b0000}, '{5'b00001, 4'h8, 4'b0000},
      '{5'b01001, 4'h0, 4'b0011}};

   gdi_top u_dut (.mclk(mclk), .rst_b(rst_b), .pwm_in_pos(pwm_in_pos),
      .pwm_in_neg_interlock(pwm_in_neg_interlock),
      .short_circuit_override_enable(short_circuit_override_enable),
      .short_circuit_level(short_circuit_level),
      .driver_enable(driver_enable), .chip_select_n(chip_select_n),
      .sclk(sclk), .sdi(sdi), .sdo(sdo), .fault_in(fault_in),
      .adc_code(adc_code), .gate_source_out(gate_source_out),
      .gate_sink_out(gate_sink_out),
      .shoot_through_fault(shoot_through_fault),
      .fault_alarm_n(fault_alarm_n), .warning_out_n(warning_out_n));

   gdi_host_model u_host (.mclk(mclk), .chip_select_n(chip_select_n),
      .sclk(sclk), .sdi(sdi), .sdo(sdo));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Applies pins, waits past the 3-edge path, compares outputs
   task automatic apply(input gdi_row_s r);
      @(negedge mclk);
      {pwm_in_pos, pwm_in_neg_interlock, short_circuit_override_enable,
       short_circuit_level, driver_enable} = r.pins;
      fault_in = r.flt;
      repeat (6) @(negedge mclk);
      check({12'h000, gate_source_out, shoot_through_fault, fault_alarm_n,
             warning_out_n}, {12'h000, r.exp});
      check({15'h0000, gate_sink_out}, {15'h0000, ~r.exp[3]});
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      {pwm_in_pos, pwm_in_neg_interlock, short_circuit_override_enable} = 3'h0;
      short_circuit_level = 1'b0;
      driver_enable = 1'b0;
      fault_in = 4'h0;
      adc_code = 10'h000;
      repeat (12) @(negedge mclk);
      check({10'h000, gate_source_out, gate_sink_out, shoot_through_fault,
             fault_alarm_n, warning_out_n, sdo}, 16'h0016);
      rst_b = 1'b1;
      foreach (rows[i]) apply(rows[i]);
      // Masks: alarm only, then both; readback is the word held at cs fall
      u_host.xfer(16'h001F, 16, rd);
      apply('{5'b11001, 4'hF, 4'b1110});
      u_host.xfer(16'h03FF, 16, rd);
      check(rd, 16'h001F);
      apply('{5'b11001, 4'hF, 4'b1111});
      // A 15-bit frame and deselected toggling leave the word alone
      u_host.xfer(16'h0000, 15, rd);
      u_host.idle_toggle();
      check({15'h0000, sdo}, 16'h0000);
      apply('{5'b11001, 4'hF, 4'b1111});
      u_host.xfer(16'h0400, 16, rd);
      check(rd, 16'h03FF);
      apply('{5'b00001, 4'h2, 4'b0000});
      // Alternate pin: high count over one ramp period equals the code
      for (int k = 0; k < 2; k++) begin
         adc_code = k ? 10'h000 : 10'h155;
         cnt = 16'h0000;
         repeat (8) @(negedge mclk);
         repeat (1024) begin
            @(negedge mclk);
            cnt = cnt + {15'h0000, warning_out_n};
         end
         check(cnt, {6'h00, adc_code});
      end
      // Host PWM at 50 kHz: gate tracks each 400-cycle half period
      for (int k = 0; k < 4; k++) begin
         pwm_in_pos = ~k[0];
         repeat (400) @(negedge mclk);
         check({14'h0000, gate_source_out, gate_sink_out},
               {14'h0000, ~k[0], k[0]});
      end
      // Mid-run reset returns outputs and configuration to defaults
      rst_b = 1'b0;
      repeat (12) @(negedge mclk);
      check({10'h000, gate_source_out, gate_sink_out, shoot_through_fault,
             fault_alarm_n, warning_out_n, sdo}, 16'h0016);
      rst_b = 1'b1;
      apply('{5'b11001, 4'h0, 4'b1100});
      finish_test();
   end

   // Hang guard
   initial begin
      repeat (60000) @(posedge mclk);
      failures++;
      finish_test();
   end
endmodule
